// ### inc/rq_desc_pkg.sv
// Descriptor field layout, sideband layout and shared enumerations.
`default_nettype none
package rq_desc_pkg;
  localparam int DESC_W     = 128;
  localparam int SB_W       = 10;
  localparam int AT_LO      = 0;
  localparam int AT_HI      = 1;
  localparam int ADDR_LO    = 2;
  localparam int ADDR_HI    = 63;
  localparam int ADDR32_LO  = 32;
  localparam int DWC_LO     = 64;
  localparam int DWC_HI     = 74;
  localparam int RT_LO      = 75;
  localparam int RT_HI      = 78;
  localparam int POISON_BIT = 79;
  localparam int FN_LO      = 80;
  localparam int FN_HI      = 87;
  localparam int FN3_HI     = 82;
  localparam int DEV_LO     = 83;
  localparam int BUS_LO     = 88;
  localparam int BUS_HI     = 95;
  localparam int TAG_LO     = 96;
  localparam int TAG_HI     = 103;
  localparam int RID_EN_BIT = 120;
  // Sideband: byte-valid masks, posted flag, address-type-applies flag.
  localparam int SB_FBE_LO  = 0;
  localparam int SB_FBE_HI  = 3;
  localparam int SB_LBE_LO  = 4;
  localparam int SB_LBE_HI  = 7;
  localparam int SB_POSTED  = 8;
  localparam int SB_MEM     = 9;
  localparam logic [1:0]  AT_UNTRANSLATED = 2'h0;
  localparam logic [1:0]  AT_RESERVED     = 2'h3;
  localparam logic [11:0] DWC_MAX         = 12'h100;
  localparam logic [11:0] DWC_ONE         = 12'h001;
  localparam logic [13:0] DW_ROUND        = 14'h0003;
  localparam logic [1:0]  LAST_LANE       = 2'h3;
  localparam logic [3:0]  BE_ALL          = 4'hf;
  localparam logic [3:0]  BE_NONE         = 4'h0;

  typedef enum logic [2:0] {
    kind_mem_rd, kind_mem_wr, kind_io_rd, kind_io_wr, kind_atomic, kind_msg
  } req_kind_t;

  typedef enum logic [1:0] {
    mode_endpoint, mode_switch_own, mode_switch_relay, mode_root_port
  } mode_t;
endpackage
`default_nettype wire

// ### inc/rq_desc_if.sv
// Request stream between the user application and the header builder.
`default_nettype none
interface rq_desc_if;
  import rq_desc_pkg::*;
  logic                desc_valid;
  logic                desc_ready;
  logic [DESC_W-1:0]   desc;
  logic [SB_W-1:0]     request_sideband_bus;

  modport device (input desc_valid, input desc, input request_sideband_bus,
                  output desc_ready);
  modport user (output desc_valid, output desc, output request_sideband_bus,
                input desc_ready);
endinterface
`default_nettype wire

// ### src/rq_header_builder.sv
// Device end: turns each accepted descriptor into request header fields.
`default_nettype none
module rq_header_builder (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  rq_desc_if.device         link,
  input  wire logic         user_tag_mgmt,
  input  wire logic         ari_enable,
  input  wire logic [7:0]   captured_bus,
  input  wire logic [4:0]   captured_dev,
  input  wire logic         hdr_ready,
  output logic              hdr_valid,
  output logic [1:0]        hdr_at,
  output logic [61:0]       hdr_addr,
  output logic [10:0]       hdr_dw_count,
  output logic [3:0]        hdr_req_type,
  output logic              hdr_poison,
  output logic [15:0]       hdr_requester_id,
  output logic [7:0]        hdr_tag,
  output logic [3:0]        hdr_first_dword_byte_valid,
  output logic [3:0]        hdr_last_dword_byte_valid
);
  import rq_desc_pkg::*;

  typedef struct packed {
    logic        ready;
    logic        hv;
    logic [1:0]  at;
    logic [61:0] addr;
    logic [10:0] dwc;
    logic [3:0]  rt;
    logic        poison;
    logic [15:0] rid;
    logic [7:0]  tag;
    logic [3:0]  fbe;
    logic [3:0]  lbe;
    logic [7:0]  tag_ctr;
  } hb_state_t;

  hb_state_t st_reg;
  hb_state_t st_next;
  logic      take;
  logic      posted;

  // A descriptor is taken while the single header slot is free.
  assign take   = link.desc_valid && st_reg.ready;
  assign posted = link.request_sideband_bus[SB_POSTED];

  // Next-state logic for the header slot and the internal tag counter.
  always_comb begin
    st_next = st_reg;
    if (st_reg.hv && hdr_ready) begin
      st_next.hv = 1'b0;
    end
    if (take) begin
      st_next.hv = 1'b1;
      // Address type is only meaningful for memory and atomic requests.
      st_next.at = link.request_sideband_bus[SB_MEM] ? link.desc[AT_HI:AT_LO]
                                                      : AT_UNTRANSLATED;
      st_next.addr = link.desc[ADDR_HI:ADDR_LO];
      // Count passes through unchecked against payload or size limits.
      st_next.dwc    = link.desc[DWC_HI:DWC_LO];
      st_next.rt     = link.desc[RT_HI:RT_LO];
      st_next.poison = link.desc[POISON_BIT];
      st_next.fbe    = link.request_sideband_bus[SB_FBE_HI:SB_FBE_LO];
      st_next.lbe    = link.request_sideband_bus[SB_LBE_HI:SB_LBE_LO];
      // Requester ID from descriptor numbers or from captured numbers.
      if (link.desc[RID_EN_BIT]) begin
        st_next.rid = {link.desc[BUS_HI:BUS_LO], link.desc[FN_HI:FN_LO]};
      end else if (ari_enable) begin
        st_next.rid = {captured_bus, link.desc[FN_HI:FN_LO]};
      end else begin
        st_next.rid = {captured_bus, captured_dev, link.desc[FN3_HI:FN_LO]};
      end
      // Posted requests keep the descriptor tag; others may use our own.
      if (posted || user_tag_mgmt) begin
        st_next.tag = link.desc[TAG_HI:TAG_LO];
      end else begin
        st_next.tag     = st_reg.tag_ctr;
        st_next.tag_ctr = st_reg.tag_ctr + 8'h01;
      end
    end
    st_next.ready = !st_next.hv;
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign link.desc_ready   = st_reg.ready;
  assign hdr_valid         = st_reg.hv;
  assign hdr_at            = st_reg.at;
  assign hdr_addr          = st_reg.addr;
  assign hdr_dw_count      = st_reg.dwc;
  assign hdr_req_type      = st_reg.rt;
  assign hdr_poison        = st_reg.poison;
  assign hdr_requester_id  = st_reg.rid;
  assign hdr_tag           = st_reg.tag;
  assign hdr_first_dword_byte_valid      = st_reg.fbe;
  assign hdr_last_dword_byte_valid       = st_reg.lbe;
endmodule // rq_header_builder
`default_nettype wire

// ### src/rq_request_builder.sv
// User end: builds request descriptors and sideband from byte-level requests.
`default_nettype none
module rq_request_builder (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  rq_desc_if.user                     link,
  input  wire logic                   req_valid,
  input  wire rq_desc_pkg::req_kind_t req_kind,
  input  wire logic [3:0]             req_type_code,
  input  wire logic [63:0]            req_addr,
  input  wire logic                   req_addr32,
  input  wire logic [12:0]            req_len_bytes,
  input  wire logic [1:0]             req_at,
  input  wire logic                   req_data_error,
  input  wire rq_desc_pkg::mode_t     req_mode,
  input  wire logic                   req_ari,
  input  wire logic [7:0]             req_function,
  input  wire logic [4:0]             req_device,
  input  wire logic [7:0]             req_bus,
  input  wire logic [7:0]             req_tag,
  output logic                        req_ready,
  output logic                        req_error
);
  import rq_desc_pkg::*;

  typedef enum logic {st_idle, st_send} phase_t;

  typedef struct packed {
    phase_t            phase;
    logic              ready;
    logic              error;
    logic              valid;
    logic [DESC_W-1:0] desc;
    logic [SB_W-1:0]   sb;
  } rb_state_t;

  rb_state_t   st_reg;
  rb_state_t   st_next;

  logic [1:0]  off;
  logic [13:0] span;
  logic [1:0]  end_off;
  logic        zero_len;
  logic [11:0] dwc;
  logic [3:0]  fbe;
  logic [3:0]  lbe;
  logic        is_mem;
  logic        is_io;
  logic        posted;
  logic        bad;
  logic [1:0]  at;
  logic [63:0] addr;
  logic [7:0]  fn_field;
  logic [7:0]  bus_field;
  logic        rid_en;

  // Dword count from byte offset and byte length, rounded up to whole Dwords.
  assign off      = req_addr[1:0];
  assign zero_len = (req_len_bytes == 13'h0000);
  assign span     = {1'b0, req_len_bytes} + {12'h000, off} + DW_ROUND;
  assign end_off  = 2'(off + req_len_bytes[1:0] - 2'h1);
  // A zero-length access is sent as one Dword with no bytes valid.
  assign dwc      = zero_len ? DWC_ONE : span[13:2];

  // Byte-valid masks for the first and last Dword of the transfer.
  always_comb begin
    fbe = 4'(BE_ALL << off);
    lbe = 4'(BE_ALL >> (LAST_LANE - end_off));
    if (zero_len) begin
      fbe = BE_NONE;
      lbe = BE_NONE;
    end else if (dwc == DWC_ONE) begin
      fbe = fbe & lbe;
      lbe = BE_NONE;
    end
  end

  // Request classification.
  assign is_mem = (req_kind == kind_mem_rd) || (req_kind == kind_mem_wr)
                  || (req_kind == kind_atomic);
  assign is_io  = (req_kind == kind_io_rd) || (req_kind == kind_io_wr);
  assign posted = (req_kind == kind_mem_wr) || (req_kind == kind_msg);

  // Requests the far end could not express are refused here.
  assign bad = (dwc > DWC_MAX)
               || (is_io && (dwc != DWC_ONE));

  // The reserved address type is never sent; it falls back to untranslated.
  assign at = (is_mem && (req_at != AT_RESERVED)) ? req_at : AT_UNTRANSLATED;

  // A 32-bit address carries zeros in the upper half.
  assign addr = req_addr32 ? {32'h0000_0000, req_addr[ADDR32_LO-1:0]} : req_addr;

  // Requester numbers and ID source for each port role.
  always_comb begin
    // Defaults suit a requester that supplies its own complete ID.
    fn_field  = req_ari ? req_function : {5'h00, req_function[2:0]};
    bus_field = req_bus;
    rid_en    = 1'b1;
    unique case (req_mode)
      mode_endpoint: begin
        // Upper function bits unused without ARI; bus unused.
        bus_field = 8'h00;
        rid_en    = 1'b0;
      end
      mode_switch_own: begin
        bus_field = req_bus;
      end
      mode_switch_relay: begin
        if (!req_ari) begin
          fn_field = {req_device, req_function[2:0]};
        end
        bus_field = req_bus;
      end
      mode_root_port: begin
        if (!req_ari) begin
          fn_field = {req_device, req_function[2:0]};
        end
        bus_field = req_bus;
      end
    endcase
  end

  // Request handshake and descriptor assembly.
  always_comb begin
    st_next       = st_reg;
    st_next.error = 1'b0;
    unique case (st_reg.phase)
      st_idle: begin
        st_next.ready = 1'b1;
        if (req_valid && st_reg.ready) begin
          // A refused request pulses the error flag and sends nothing.
          if (bad) begin
            st_next.error = 1'b1;
          end else begin
            st_next.desc                       = '0;
            st_next.desc[AT_HI:AT_LO]          = at;
            st_next.desc[ADDR_HI:ADDR_LO]      = addr[ADDR_HI:ADDR_LO];
            st_next.desc[DWC_HI:DWC_LO]        = dwc[10:0];
            st_next.desc[RT_HI:RT_LO]          = req_type_code;
            st_next.desc[POISON_BIT]           = req_data_error;
            st_next.desc[FN_HI:FN_LO]          = fn_field;
            st_next.desc[BUS_HI:BUS_LO]        = bus_field;
            st_next.desc[TAG_HI:TAG_LO]        = req_tag;
            st_next.desc[RID_EN_BIT]           = rid_en;
            // Sideband carries the byte masks and the request class flags.
            st_next.sb                         = '0;
            st_next.sb[SB_FBE_HI:SB_FBE_LO]    = fbe;
            st_next.sb[SB_LBE_HI:SB_LBE_LO]    = lbe;
            st_next.sb[SB_POSTED]              = posted;
            st_next.sb[SB_MEM]                 = is_mem;
            // The whole descriptor goes out in a single beat.
            st_next.valid = 1'b1;
            st_next.ready = 1'b0;
            st_next.phase = st_send;
          end
        end
      end
      st_send: begin
        // The descriptor stays unchanged until the device end takes it.
        if (link.desc_ready) begin
          st_next.valid = 1'b0;
          st_next.ready = 1'b1;
          st_next.phase = st_idle;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign link.desc_valid           = st_reg.valid;
  assign link.desc                 = st_reg.desc;
  assign link.request_sideband_bus = st_reg.sb;
  assign req_ready                 = st_reg.ready;
  assign req_error                 = st_reg.error;
endmodule // rq_request_builder
`default_nettype wire

// ### tb/rq_desc_properties.sv
// Protocol checks on the descriptor link between the two ends.
`default_nettype none
module rq_desc_properties
  import rq_desc_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              desc_valid,
  input wire logic              desc_ready,
  input wire logic [DESC_W-1:0] desc,
  input wire logic [SB_W-1:0]   request_sideband_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Short names for the fields under check.
  logic [10:0] dwc;
  logic [3:0]  fbe;
  logic [3:0]  lbe;
  assign dwc = desc[DWC_HI:DWC_LO];
  assign fbe = request_sideband_bus[SB_FBE_HI:SB_FBE_LO];
  assign lbe = request_sideband_bus[SB_LBE_HI:SB_LBE_LO];
  // A descriptor handed over, and one left waiting.
  sequence offer_s;
    desc_valid && desc_ready;
  endsequence
  sequence stall_s;
    desc_valid && !desc_ready;
  endsequence
  desc_hold_a: assert property (stall_s |=> desc_valid && $stable(desc))
    else $error("descriptor changed while waiting");
  single_beat_a: assert property (offer_s |=> !desc_valid)
    else $error("descriptor offered twice");
  slot_full_a: assert property (offer_s |=> !desc_ready)
    else $error("slot still free after take");
  at_reserved_a: assert property (desc_valid |-> desc[AT_HI:AT_LO] != AT_RESERVED)
    else $error("reserved address type sent");
  at_nonmem_a: assert property (desc_valid && !request_sideband_bus[SB_MEM]
    |-> desc[AT_HI:AT_LO] == AT_UNTRANSLATED) else $error("address type on non-memory");
  dwc_range_a: assert property (desc_valid |-> {1'b0, dwc} <= DWC_MAX)
    else $error("dword count above range");
  zero_len_a: assert property (desc_valid && fbe == BE_NONE
    |-> dwc == 11'h001 && lbe == BE_NONE) else $error("bad zero length encoding");
  one_dword_a: assert property (desc_valid && dwc == 11'h001 |-> lbe == BE_NONE)
    else $error("last mask set on one dword");
  io_count_a: assert property (desc_valid && request_sideband_bus[SB_MEM:SB_POSTED] == 2'h0
    |-> dwc == 11'h001) else $error("io count not one");
endmodule // rq_desc_properties
`default_nettype wire

// ### tb/test_pcie_request_descriptor_fields.sv
// Bench joining the request builder to the header builder.
`default_nettype none
`define CHK(nm, e, g) \
  check_count++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end
module test_pcie_request_descriptor_fields
  import rq_desc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_addr32 = 1'b0;
  logic        req_data_error = 1'b0, req_ari = 1'b0, user_tag_mgmt = 1'b0;
  logic        ari_enable = 1'b0, hdr_ready = 1'b0;
  logic        req_ready, req_error, hdr_valid, hdr_poison;
  req_kind_t   req_kind = kind_mem_wr;
  mode_t       req_mode = mode_endpoint;
  logic [3:0]  req_type_code = 4'h0, hdr_req_type, hdr_first_dword_byte_valid, hdr_last_dword_byte_valid;
  logic [63:0] req_addr = 64'h0;
  logic [12:0] req_len_bytes = 13'h0;
  logic [1:0]  req_at = 2'h0, hdr_at;
  logic [7:0]  req_function = 8'h0, req_bus = 8'h0, req_tag = 8'h0, hdr_tag;
  logic [7:0]  captured_bus = 8'h3c;
  logic [4:0]  req_device = 5'h0, captured_dev = 5'h0a;
  logic [61:0] hdr_addr;
  logic [10:0] hdr_dw_count;
  logic [15:0] hdr_requester_id;
  int          num_errors = 0, check_count = 0, cycles = 0;
  rq_desc_if link_if ();
  rq_request_builder rq_request_builder_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link_if),
    .req_valid(req_valid), .req_kind(req_kind), .req_type_code(req_type_code),
    .req_addr(req_addr), .req_addr32(req_addr32), .req_len_bytes(req_len_bytes),
    .req_at(req_at), .req_data_error(req_data_error), .req_mode(req_mode), .req_ari(req_ari),
    .req_function(req_function), .req_device(req_device), .req_bus(req_bus),
    .req_tag(req_tag), .req_ready(req_ready), .req_error(req_error));
  rq_header_builder rq_header_builder_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(link_if),
    .user_tag_mgmt(user_tag_mgmt), .ari_enable(ari_enable), .captured_bus(captured_bus),
    .captured_dev(captured_dev), .hdr_ready(hdr_ready), .hdr_valid(hdr_valid),
    .hdr_at(hdr_at), .hdr_addr(hdr_addr), .hdr_dw_count(hdr_dw_count),
    .hdr_req_type(hdr_req_type), .hdr_poison(hdr_poison),
    .hdr_requester_id(hdr_requester_id), .hdr_tag(hdr_tag), .hdr_first_dword_byte_valid(hdr_first_dword_byte_valid),
    .hdr_last_dword_byte_valid(hdr_last_dword_byte_valid));
  rq_desc_properties rq_desc_properties_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .desc_valid(link_if.desc_valid), .desc_ready(link_if.desc_ready), .desc(link_if.desc),
    .request_sideband_bus(link_if.request_sideband_bus));
  // Free-running system clock.
  always #25 clk_sys = ~clk_sys;
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short well after the tests should have ended.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  // Offers one request and holds it until the builder takes it.
  task automatic req(input req_kind_t k, input logic [63:0] a, input logic [12:0] l);
    @(posedge clk_sys) #1;
    req_kind = k;
    req_addr = a;
    req_len_bytes = l;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
  endtask
  // Waits for the header, stalls it two cycles, compares every field, then takes it.
  task automatic expect_hdr(input logic [1:0] at, input logic [61:0] ad,
      input logic [10:0] dc, input logic [3:0] fb, input logic [3:0] lb,
      input logic [15:0] rid, input logic [7:0] tg);
    repeat (20) if (hdr_valid !== 1'b1) @(posedge clk_sys) #1;
    repeat (2) @(posedge clk_sys) #1;
    `CHK("hdr_valid", 1'b1, hdr_valid)
    `CHK("hdr_at", at, hdr_at)
    `CHK("hdr_addr", ad, hdr_addr)
    `CHK("hdr_dw_count", dc, hdr_dw_count)
    `CHK("hdr_req_type", req_type_code, hdr_req_type)
    `CHK("hdr_poison", req_data_error, hdr_poison)
    `CHK("hdr_requester_id", rid, hdr_requester_id)
    `CHK("hdr_tag", tg, hdr_tag)
    `CHK("hdr_first_dword_byte_valid", fb, hdr_first_dword_byte_valid)
    `CHK("hdr_last_dword_byte_valid", lb, hdr_last_dword_byte_valid)
    hdr_ready = 1'b1;
    @(posedge clk_sys) #1;
    hdr_ready = 1'b0;
  endtask
  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    // Poisoned posted write from an endpoint without ARI.
    {req_type_code, req_data_error, req_function, req_tag, req_at} = {4'h1, 1'b1, 16'hfda7, 2'h2};
    req(kind_mem_wr, 64'h1_0000_0006, 13'h8);
    `CHK("req_ready", 1'b0, req_ready)
    expect_hdr(2'h2, 62'h4000_0001, 11'h003, 4'hc, 4'h3, 16'h3c55, 8'ha7);
    $display("test 1 done");
    // Zero length read, reserved address type, 32-bit address, root port with ARI.
    {req_type_code, req_data_error, req_at, req_addr32} = {4'h0, 1'b0, 2'h3, 1'b1};
    req_mode = mode_root_port;
    {req_ari, ari_enable, req_bus, req_function} = {2'h3, 16'h429b};
    req(kind_mem_rd, 64'hffff_0000_0000_0010, 13'h0);
    expect_hdr(2'h0, 62'h4, 11'h001, 4'h0, 4'h0, 16'h429b, 8'h00);
    $display("test 2 done");
    // Refused requests back to back: wide I/O, then an oversize write.
    req(kind_io_rd, 64'h20, 13'h8);
    `CHK("req_error", 1'b1, req_error)
    `CHK("req_ready", 1'b1, req_ready)
    req(kind_mem_wr, 64'h0, 13'h404);
    `CHK("req_error", 1'b1, req_error)
    `CHK("desc_valid", 1'b0, link_if.desc_valid)
    $display("test 3 done");
    // Full 256 dword read relayed by a switch without ARI, user-managed tag.
    req_mode = mode_switch_relay;
    {req_ari, ari_enable, user_tag_mgmt} = 3'h1;
    {req_device, req_function, req_bus, req_tag, req_at} = {5'h13, 24'h067e5a, 2'h1};
    req_addr32 = 1'b0;
    req(kind_mem_rd, 64'h2_0000_0100, 13'h400);
    // Let the device end take this descriptor before the settings change.
    @(posedge clk_sys) #1;
    // One dword I/O write from an endpoint with ARI, internal tag, queued behind test 4.
    req_mode = mode_endpoint;
    {req_ari, ari_enable, user_tag_mgmt} = 3'h6;
    {req_function, req_at} = {8'hc1, 2'h2};
    req(kind_io_wr, 64'h304, 13'h4);
    `CHK("desc_ready", 1'b0, link_if.desc_ready)
    `CHK("desc_valid", 1'b1, link_if.desc_valid)
    expect_hdr(2'h1, 62'h8000_0040, 11'h100, 4'hf, 4'hf, 16'h7e9e, 8'h5a);
    $display("test 4 done");
    expect_hdr(2'h0, 62'hc1, 11'h001, 4'hf, 4'h0, 16'h3cc1, 8'h01);
    $display("test 5 done");
    // A switch sends its own atomic with an internal tag, then a message with its descriptor tag, with ARI.
    req_mode = mode_switch_own;
    {req_ari, ari_enable, user_tag_mgmt} = 3'h6;
    {req_function, req_bus, req_tag, req_at} = {24'h245d3e, 2'h1};
    req(kind_atomic, 64'h1000, 13'h8);
    expect_hdr(2'h1, 62'h400, 11'h002, 4'hf, 4'hf, 16'h5d24, 8'h02);
    req(kind_msg, 64'h0, 13'h4);
    expect_hdr(2'h0, 62'h0, 11'h001, 4'hf, 4'h0, 16'h5d24, 8'h3e);
    $display("test 6 done");
    end_sim();
  end
endmodule // test_pcie_request_descriptor_fields
`default_nettype wire
